// file: ptl_mapper.v
// Summary of operation
// - PCI side is always little-endian
// - Global order bit, big-endian after reset
// - Image invert flips order, target channel only
// - Big-endian: keep addresses, swap lanes
// - Little-endian: keep lanes, translate addresses
// - Image width selects 32, 16, 8-bit port
// - Odd write enables become byte writes
// - Size codes: byte 01, half 10, word 00
// - Little-endian 32-bit write address table
// - Little-endian write data lane replication
// - Big-endian 32-bit write address table
// - Big-endian write data byte swapped
// - Narrow ports split wide writes
// - Little-endian 32-bit reads use original lanes
// - Odd 32-bit port reads become bytes
// - Little-endian 16-bit port read lanes
// - Big-endian 16-bit port read lanes
// - 16-bit port splits odd and word reads
// - 8-bit port reads use top lane
// - 8-bit port splits all wider reads
// - Enables and port width drive packing
`timescale 1ns/1ps
`include "ptl_map.vh"

module ptl_mapper (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Configuration from same clock domain
  input wire local_bus_byte_order,
  input wire image_endian_invert,
  input wire [1:0] image_port_width,
  // PCI target data phase request
  input wire req_valid,
  output wire req_ready,
  input wire req_write,
  input wire [3:0] req_be_b,
  input wire [31:0] req_wdata,
  // PCI target completion
  output reg rsp_valid_r,
  output reg rsp_err_r,
  output reg [31:0] rsp_rdata_r,
  // Local processor bus cycle
  output reg lb_valid_r,
  output reg lb_write_r,
  output reg [1:0] transfer_size_code_r,
  output reg [1:0] lb_addr_r,
  output reg [31:0] lb_wdata_r,
  input wire lb_ack,
  input wire lb_err,
  input wire [31:0] lb_rdata,
  // Status
  output reg busy_r,
  output reg order_big_r
);
  // Request word layout in the FIFO
  wire [`PTL_REQ_W-1:0] fifo_in;
  wire [`PTL_REQ_W-1:0] fifo_out;
  wire fifo_valid;
  wire fifo_pop;
  wire fifo_ready;

  // Sequencer states
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_SETUP = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;

  // Fields of the request at the FIFO head
  wire head_write;
  wire [3:0] head_en;
  wire [31:0] head_wdata;

  // Latched request
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg write_r;
  reg [3:0] orig_en_r;
  reg [3:0] rem_r;
  reg [31:0] wdata_r;
  reg big_r;
  reg [1:0] port_r;
  reg [31:0] acc_r;
  reg err_r;
  reg [3:0] piece_r;

  // Piece selection
  reg [3:0] piece_nxt;
  reg [1:0] siz_nxt;
  reg [1:0] addr_nxt;
  wire aligned;
  wire allow_word;
  wire allow_half;
  wire [3:0] byte_pick;
  wire [3:0] rem_rev;
  wire [3:0] low_rev;
  wire [3:0] low_fwd;

  // Lane mapper results
  wire [31:0] map_wdata;
  wire [31:0] map_rd;
  wire [31:0] map_mask;
  wire [31:0] acc_nxt;
  wire [3:0] rem_nxt;
  wire eff_big;

  // Cycle view handed to the lane mapper
  wire in_wait;
  wire [1:0] view_siz;
  wire [1:0] view_addr;
  wire [3:0] view_piece;

  // Effective order for this image: global bit flipped by invert
  assign eff_big = order_big_r ^ image_endian_invert;

  // Pack request into FIFO word
  assign fifo_in = {req_write, req_be_b, req_wdata};
  assign req_ready = fifo_ready;
  assign fifo_pop = (state_r == ST_IDLE) & fifo_valid;

  // Unpack the head request, enables turned active high
  assign head_write = fifo_out[`PTL_REQ_WR];
  assign head_en = ~fifo_out[`PTL_REQ_BE_HI:`PTL_REQ_BE_LO];
  assign head_wdata = fifo_out[`PTL_REQ_WD_HI:`PTL_REQ_WD_LO];

  ptl_fifo #(
    .WIDTH(`PTL_REQ_W),
    .DEPTH(`PTL_FIFO_DEPTH),
    .AW(`PTL_FIFO_AW)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .in_valid(req_valid),
    .in_ready(fifo_ready),
    .in_data(fifo_in),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );

  // Whole word or aligned halfword patterns may stay wide
  assign aligned = (orig_en_r == `PTL_MASK_ALL) |
                   (orig_en_r == `PTL_MASK_LOW) |
                   (orig_en_r == `PTL_MASK_HIGH);
  assign allow_word = (orig_en_r == `PTL_MASK_ALL) &
                      (port_r == `PTL_PORT_32);
  assign allow_half = aligned & (port_r != `PTL_PORT_8);

  // Byte order of issue: ascending local address
  assign low_fwd = rem_r & (~rem_r + `PTL_MASK_ONE);
  assign rem_rev = {rem_r[0], rem_r[1], rem_r[2], rem_r[3]};
  assign low_rev = rem_rev & (~rem_rev + `PTL_MASK_ONE);
  assign byte_pick = big_r ? low_fwd :
                     {low_rev[0], low_rev[1], low_rev[2], low_rev[3]};

  // Next piece, size code and low address
  always @*
  begin
    piece_nxt = byte_pick;
    siz_nxt = `PTL_SIZ_BYTE;
    addr_nxt = `PTL_ADDR_00;
    if (allow_word)
    begin
      piece_nxt = `PTL_MASK_ALL;
      siz_nxt = `PTL_SIZ_WORD;
      addr_nxt = `PTL_ADDR_00;
    end
    else if (allow_half)
    begin
      siz_nxt = `PTL_SIZ_HALF;
      if (big_r)
      begin
        // Big-endian: low PCI half sits at address 00
        if ((rem_r & `PTL_MASK_LOW) == `PTL_MASK_LOW)
          piece_nxt = `PTL_MASK_LOW;
        else
          piece_nxt = `PTL_MASK_HIGH;
        addr_nxt = (piece_nxt == `PTL_MASK_LOW) ?
                   `PTL_ADDR_00 : `PTL_ADDR_10;
      end
      else
      begin
        // Little-endian: high PCI half sits at address 00
        if ((rem_r & `PTL_MASK_HIGH) == `PTL_MASK_HIGH)
          piece_nxt = `PTL_MASK_HIGH;
        else
          piece_nxt = `PTL_MASK_LOW;
        addr_nxt = (piece_nxt == `PTL_MASK_HIGH) ?
                   `PTL_ADDR_00 : `PTL_ADDR_10;
      end
    end
    else
    begin
      // Byte k: address k big-endian, 3-k little-endian
      case (byte_pick)
        `PTL_MASK_ONE: addr_nxt = big_r ? `PTL_ADDR_00 : `PTL_ADDR_11;
        `PTL_MASK_B1: addr_nxt = big_r ? `PTL_ADDR_01 : `PTL_ADDR_10;
        `PTL_MASK_B2: addr_nxt = big_r ? `PTL_ADDR_10 : `PTL_ADDR_01;
        default: addr_nxt = big_r ? `PTL_ADDR_11 : `PTL_ADDR_00;
      endcase
    end
  end

  // While waiting the registered cycle, else the piece being set up
  assign in_wait = (state_r == ST_WAIT);
  assign view_siz = in_wait ? transfer_size_code_r : siz_nxt;
  assign view_addr = in_wait ? lb_addr_r : addr_nxt;
  assign view_piece = in_wait ? piece_r : piece_nxt;

  // Lane placement for the piece being set up or returned
  ptl_lanes u_lanes (
    .big(big_r),
    .port_w(port_r),
    .siz(view_siz),
    .addr(view_addr),
    .piece(view_piece),
    .pci_wdata(wdata_r),
    .lb_rdata(lb_rdata),
    .lb_wdata(map_wdata),
    .rd_pci(map_rd),
    .lane_mask(map_mask)
  );

  // Read assembly and remaining lanes after an acknowledge
  assign acc_nxt = (acc_r & ~map_mask) | (map_rd & map_mask);
  assign rem_nxt = rem_r & ~piece_r;

  // Sequencer next state
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (fifo_valid)
          state_nxt = ST_SETUP;
      ST_SETUP:
        // An all-disabled request skips the local bus
        if (rem_r == `PTL_MASK_NONE)
          state_nxt = ST_IDLE;
        else
          state_nxt = ST_WAIT;
      ST_WAIT:
        // Back to setup until every lane has been moved
        if (lb_ack)
          state_nxt = (rem_nxt == `PTL_MASK_NONE) ?
                      ST_IDLE : ST_SETUP;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Global order register, big-endian out of reset
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      order_big_r <= `PTL_ORDER_RESET;
    else
      order_big_r <= (local_bus_byte_order == `PTL_ORDER_BIG);
  end

  // Request latch and local bus cycle generation
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= ST_IDLE;
      write_r <= 1'b0;
      orig_en_r <= `PTL_MASK_NONE;
      rem_r <= `PTL_MASK_NONE;
      wdata_r <= 32'h00000000;
      big_r <= `PTL_ORDER_RESET;
      port_r <= `PTL_PORT_32;
      acc_r <= 32'h00000000;
      err_r <= 1'b0;
      piece_r <= `PTL_MASK_NONE;
      lb_valid_r <= 1'b0;
      lb_write_r <= 1'b0;
      transfer_size_code_r <= `PTL_SIZ_WORD;
      lb_addr_r <= `PTL_ADDR_00;
      lb_wdata_r <= 32'h00000000;
      rsp_valid_r <= 1'b0;
      rsp_err_r <= 1'b0;
      rsp_rdata_r <= 32'h00000000;
      busy_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      rsp_valid_r <= 1'b0;
      case (state_r)
        ST_IDLE:
          if (fifo_valid)
          begin
            // PCI data taken as little-endian lanes
            write_r <= head_write;
            orig_en_r <= head_en;
            rem_r <= head_en;
            wdata_r <= head_wdata;
            big_r <= eff_big;
            port_r <= (image_port_width == `PTL_PORT_16 ||
                       image_port_width == `PTL_PORT_8) ?
                      image_port_width : `PTL_PORT_32;
            acc_r <= 32'h00000000;
            err_r <= 1'b0;
            busy_r <= 1'b1;
          end
        ST_SETUP:
          if (rem_r == `PTL_MASK_NONE)
          begin
            // No lanes enabled: complete with no local cycle
            rsp_valid_r <= 1'b1;
            rsp_err_r <= 1'b0;
            rsp_rdata_r <= 32'h00000000;
            busy_r <= 1'b0;
          end
          else
          begin
            // Launch the next piece, held until acknowledged
            piece_r <= piece_nxt;
            lb_valid_r <= 1'b1;
            lb_write_r <= write_r;
            transfer_size_code_r <= siz_nxt;
            lb_addr_r <= addr_nxt;
            lb_wdata_r <= write_r ? map_wdata : 32'h00000000;
          end
        ST_WAIT:
          if (lb_ack)
          begin
            // Retire the piece; an error is noted, the rest still runs
            lb_valid_r <= 1'b0;
            rem_r <= rem_nxt;
            if (!write_r)
              acc_r <= acc_nxt;
            err_r <= err_r | lb_err;
            if (rem_nxt == `PTL_MASK_NONE)
            begin
              // Completion only after the last piece returns
              rsp_valid_r <= 1'b1;
              rsp_err_r <= err_r | lb_err;
              rsp_rdata_r <= write_r ? 32'h00000000 : acc_nxt;
              busy_r <= 1'b0;
            end
          end
        default:
          lb_valid_r <= 1'b0;
      endcase
    end
  end
endmodule // ptl_mapper

// file: ptl_map.vh
`ifndef PTL_MAP_VH
`define PTL_MAP_VH

// Local bus byte order encodings
`define PTL_ORDER_LITTLE 1'b0
`define PTL_ORDER_BIG 1'b1
`define PTL_ORDER_RESET 1'b1

// Image port width encodings
`define PTL_PORT_32 2'h0
`define PTL_PORT_16 2'h1
`define PTL_PORT_8 2'h2

// Transfer size codes on the local bus
`define PTL_SIZ_BYTE 2'h1
`define PTL_SIZ_HALF 2'h2
`define PTL_SIZ_WORD 2'h0

// Low local address values
`define PTL_ADDR_00 2'h0
`define PTL_ADDR_01 2'h1
`define PTL_ADDR_10 2'h2
`define PTL_ADDR_11 2'h3

// Lane masks, active high, bit k is PCI byte k
`define PTL_MASK_NONE 4'h0
`define PTL_MASK_ALL 4'hF
`define PTL_MASK_LOW 4'h3
`define PTL_MASK_HIGH 4'hC
`define PTL_MASK_ONE 4'h1
`define PTL_MASK_B1 4'h2
`define PTL_MASK_B2 4'h4

// Request FIFO shape
`define PTL_FIFO_DEPTH 4
`define PTL_FIFO_AW 2
`define PTL_REQ_W 37

// Request word fields: write flag, enables, data
`define PTL_REQ_WR 36
`define PTL_REQ_BE_HI 35
`define PTL_REQ_BE_LO 32
`define PTL_REQ_WD_HI 31
`define PTL_REQ_WD_LO 0

`endif

// file: ptl_fifo.v
`timescale 1ns/1ps
`include "ptl_map.vh"

module ptl_fifo #(
  parameter WIDTH = `PTL_REQ_W,
  parameter DEPTH = `PTL_FIFO_DEPTH,
  parameter AW = `PTL_FIFO_AW
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Filling side
  input wire in_valid,
  output reg in_ready,
  input wire [WIDTH-1:0] in_data,
  // Draining side
  output reg out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;
  wire [AW:0] count_nxt;

  // Handshakes on both sides
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_data = mem_r[rd_ptr_r];

  // Storage writes
  always @(posedge core_clk)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data;
  end

  // Pointers and registered flags
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      count_r <= count_nxt;
      in_ready <= (count_nxt != DEPTH[AW:0]);
      out_valid <= (count_nxt != {(AW+1){1'b0}});
    end
  end
endmodule // ptl_fifo

// file: ptl_lanes.v
`timescale 1ns/1ps
`include "ptl_map.vh"

module ptl_lanes (
  // Cycle description
  input wire big,
  input wire [1:0] port_w,
  input wire [1:0] siz,
  input wire [1:0] addr,
  input wire [3:0] piece,
  // Data in
  input wire [31:0] pci_wdata,
  input wire [31:0] lb_rdata,
  // Data out
  output reg [31:0] lb_wdata,
  output reg [31:0] rd_pci,
  output wire [31:0] lane_mask
);
  wire [31:0] wsel;
  wire [7:0] wbyte;
  wire [15:0] whalf;
  reg [7:0] rbyte;
  reg [15:0] rhalf;
  reg [1:0] lane;

  // Per lane bit mask of the active piece
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_lane
      assign lane_mask[8*i+7:8*i] = {8{piece[i]}};
    end
  endgenerate

  // Write byte or half picked from PCI lanes
  assign wsel = pci_wdata & lane_mask;
  assign wbyte = wsel[31:24] | wsel[23:16] | wsel[15:8] | wsel[7:0];
  assign whalf = piece[3] ? pci_wdata[31:16] : pci_wdata[15:0];

  // Write lane placement with replication or swap
  always @*
  begin
    case (siz)
      `PTL_SIZ_BYTE: lb_wdata = {wbyte, wbyte, wbyte, wbyte};
      `PTL_SIZ_HALF:
        if (big)
          lb_wdata = {whalf[7:0], whalf[15:8], whalf[7:0], whalf[15:8]};
        else
          lb_wdata = {whalf, whalf};
      default:
        if (big)
          lb_wdata = {pci_wdata[7:0], pci_wdata[15:8],
                      pci_wdata[23:16], pci_wdata[31:24]};
        else
          lb_wdata = pci_wdata;
    endcase
  end

  // Read lane selection by port width
  always @*
  begin
    case (port_w)
      `PTL_PORT_32: lane = addr;
      `PTL_PORT_16: lane = {1'b0, addr[0]};
      default: lane = 2'h0;
    endcase
    case (lane)
      2'h0: rbyte = lb_rdata[31:24];
      2'h1: rbyte = lb_rdata[23:16];
      2'h2: rbyte = lb_rdata[15:8];
      default: rbyte = lb_rdata[7:0];
    endcase
    if ((port_w == `PTL_PORT_32) && addr[1])
      rhalf = lb_rdata[15:0];
    else
      rhalf = lb_rdata[31:16];
    case (siz)
      `PTL_SIZ_BYTE: rd_pci = {rbyte, rbyte, rbyte, rbyte};
      `PTL_SIZ_HALF:
        if (big)
          rd_pci = {rhalf[7:0], rhalf[15:8], rhalf[7:0], rhalf[15:8]};
        else
          rd_pci = {rhalf, rhalf};
      default:
        if (big)
          rd_pci = {lb_rdata[7:0], lb_rdata[15:8],
                    lb_rdata[23:16], lb_rdata[31:24]};
        else
          rd_pci = lb_rdata;
    endcase
  end
endmodule // ptl_lanes

// file: ptl_mapper_sva.sv
`timescale 1ns/1ps
`include "ptl_map.vh"

module ptl_mapper_sva (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Configuration and request
  input wire [1:0] image_port_width,
  input wire req_ready,
  // Completion
  input wire rsp_valid_r,
  input wire rsp_err_r,
  // Local bus cycle
  input wire lb_valid_r,
  input wire lb_write_r,
  input wire [1:0] transfer_size_code_r,
  input wire [1:0] lb_addr_r,
  input wire [31:0] lb_wdata_r,
  input wire lb_ack,
  // Status
  input wire order_big_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // Cycle shape versus size and port width
  chk_size_legal: assert property (
    lb_valid_r |-> transfer_size_code_r != 2'h3) else $error("bad size");
  chk_port8_bytes: assert property (
    lb_valid_r && image_port_width == `PTL_PORT_8
    |-> transfer_size_code_r == `PTL_SIZ_BYTE) else $error("wide on 8");
  chk_port16_noword: assert property (
    lb_valid_r && image_port_width == `PTL_PORT_16
    |-> transfer_size_code_r != `PTL_SIZ_WORD) else $error("word on 16");
  chk_word_addr: assert property (
    lb_valid_r && transfer_size_code_r == `PTL_SIZ_WORD
    |-> lb_addr_r == `PTL_ADDR_00) else $error("word misaligned");
  chk_half_addr: assert property (
    lb_valid_r && transfer_size_code_r == `PTL_SIZ_HALF
    |-> !lb_addr_r[0]) else $error("half misaligned");
  chk_byte_repl: assert property (
    lb_valid_r && lb_write_r && transfer_size_code_r == `PTL_SIZ_BYTE
    |-> lb_wdata_r[31:16] == lb_wdata_r[15:0]
    && lb_wdata_r[15:8] == lb_wdata_r[7:0]) else $error("byte lanes");
  // Handshake on the local bus, completion pulse and order after reset
  chk_cycle_hold: assert property (
    lb_valid_r && !lb_ack |=> lb_valid_r && $stable({lb_write_r,
    transfer_size_code_r, lb_addr_r, lb_wdata_r})) else $error("moved");
  chk_ack_drop: assert property (
    lb_valid_r && lb_ack |=> !lb_valid_r) else $error("no drop");
  chk_rsp_pulse: assert property (
    rsp_valid_r |-> !lb_valid_r ##1 !rsp_valid_r) else $error("rsp early");
  chk_order_reset: assert property (
    $rose(rst_b) |-> order_big_r) else $error("order not big");

  // Main scenarios
  cov_word: cover property (lb_valid_r && lb_ack
    && transfer_size_code_r == `PTL_SIZ_WORD);
  cov_err: cover property (rsp_valid_r && rsp_err_r);
  cov_full: cover property (!req_ready ##1 req_ready);
endmodule // ptl_mapper_sva

bind ptl_mapper ptl_mapper_sva chk_u (.*);

// file: ptl_lb_peer.sv
`timescale 1ns/1ps
`include "ptl_map.vh"

module ptl_lb_peer (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Local cycle
  input wire lb_valid_r,
  input wire [1:0] transfer_size_code_r,
  input wire [1:0] lb_addr_r,
  // Peripheral setup
  input wire [1:0] port_w,
  input wire [31:0] mem_word,
  input wire [1:0] stall,
  input wire err_en,
  // Answer
  output reg lb_ack,
  output reg lb_err,
  output reg [31:0] lb_rdata
);
  reg [1:0] wait_r;

  // Addressed bytes on the lanes of the port, rest garbage
  function [31:0] lanes(input [1:0] sz, input [1:0] a);
    reg [15:0] h;
    integer ln;
    begin
      h = a[1] ? mem_word[15:0] : mem_word[31:16];
      ln = (port_w == `PTL_PORT_8) ? 0 : (port_w == `PTL_PORT_16) ? a[0] : a;
      lanes = ~lb_rdata;
      if (sz == `PTL_SIZ_WORD)
        lanes = mem_word;
      else if (sz == `PTL_SIZ_HALF && port_w == `PTL_PORT_32 && a[1])
        lanes[15:0] = h;
      else if (sz == `PTL_SIZ_HALF)
        lanes[31:16] = h;
      else
        lanes[31-8*ln -: 8] = mem_word[31-8*a -: 8];
    end
  endfunction

  // Answers after a stall, data toggles when not answering
  always @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      lb_ack <= 1'b0;
      lb_err <= 1'b0;
      wait_r <= 2'h0;
      lb_rdata <= 32'h0;
    end
    else
    begin
      lb_ack <= 1'b0;
      lb_err <= 1'b0;
      lb_rdata <= ~lb_rdata;
      if (lb_ack)
        wait_r <= stall;
      else if (lb_valid_r && wait_r != 2'h0)
        wait_r <= wait_r - 2'h1;
      else if (lb_valid_r)
      begin
        lb_ack <= 1'b1;
        lb_err <= err_en;
        lb_rdata <= lanes(transfer_size_code_r, lb_addr_r);
      end
    end
endmodule // ptl_lb_peer

// file: pci_target_endian_lane_mapper_test.sv
`timescale 1ns/1ps
`include "ptl_map.vh"

module pci_target_endian_lane_mapper_test;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic lbo = 1'b0, inv = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic err_en = 1'b0;
  logic [1:0] pw = 2'h0, stall = 2'h0;
  logic [3:0] req_be_b = 4'hF;
  logic [31:0] req_wdata = 32'h0, mem_word = 32'h0;
  wire req_ready, rsp_valid_r, rsp_err_r, lb_valid_r, lb_write_r;
  wire lb_ack, lb_err, busy_r, order_big_r;
  wire [1:0] transfer_size_code_r, lb_addr_r;
  wire [31:0] rsp_rdata_r, lb_wdata_r, lb_rdata;
  logic [36:0] lb_q[$];
  logic [64:0] rsp_q[$];
  integer miscompares = 0, num_checks = 0, seed = 83;

  always #25 core_clk = ~core_clk;

  ptl_mapper dut_u (.core_clk(core_clk), .rst_b(rst_b),
    .local_bus_byte_order(lbo), .image_endian_invert(inv),
    .image_port_width(pw), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_be_b(req_be_b), .req_wdata(req_wdata),
    .rsp_valid_r(rsp_valid_r), .rsp_err_r(rsp_err_r),
    .rsp_rdata_r(rsp_rdata_r), .lb_valid_r(lb_valid_r),
    .lb_write_r(lb_write_r), .transfer_size_code_r(transfer_size_code_r),
    .lb_addr_r(lb_addr_r), .lb_wdata_r(lb_wdata_r), .lb_ack(lb_ack),
    .lb_err(lb_err), .lb_rdata(lb_rdata), .busy_r(busy_r),
    .order_big_r(order_big_r));

  ptl_lb_peer peer_u (.core_clk(core_clk), .rst_b(rst_b),
    .lb_valid_r(lb_valid_r), .transfer_size_code_r(transfer_size_code_r),
    .lb_addr_r(lb_addr_r), .port_w(pw), .mem_word(mem_word),
    .stall(stall), .err_en(err_en), .lb_ack(lb_ack), .lb_err(lb_err),
    .lb_rdata(lb_rdata));

  // Verdict and end of run
  task stop_test;
    begin
      $display("Checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  // Compare and count
  task check(input logic [63:0] seen, input logic [63:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
        miscompares = miscompares + 1;
        $display("Error at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  function logic [31:0] swap(input logic [31:0] w);
    swap = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  // Expected local cycles and completion of one request
  task plan(input logic wr, input logic [3:0] be, input logic [31:0] wd);
    logic big;
    logic [15:0] h;
    logic [31:0] m;
    integer i, k, n;
    begin
      big = lbo ^ inv;
      n = 0;
      if (be == 4'h0 && pw == `PTL_PORT_32)
      begin
        m = big ? swap(wd) : wd;
        lb_q.push_back({wr, `PTL_SIZ_WORD, `PTL_ADDR_00, wr ? m : 32'h0});
        n = 1;
      end
      else if ((be == 4'h0 || be == 4'h3 || be == 4'hC) && pw != `PTL_PORT_8)
        for (i = 0; i < 4; i = i + 2)
        begin
          k = (big ^ (i == 0)) ? 1 : 0;
          h = k ? wd[31:16] : wd[15:0];
          if (big)
            h = {h[7:0], h[15:8]};
          if (be[2*k +: 2] == 2'h0)
          begin
            lb_q.push_back({wr, `PTL_SIZ_HALF, i[1:0], wr ? {h, h} : 32'h0});
            n = n + 1;
          end
        end
      else
        for (i = 0; i < 4; i = i + 1)
        begin
          k = big ? i : 3 - i;
          if (!be[k])
          begin
            lb_q.push_back({wr, `PTL_SIZ_BYTE, i[1:0],
              wr ? {4{wd[8*k +: 8]}} : 32'h0});
            n = n + 1;
          end
        end
      m = {{8{~be[3]}}, {8{~be[2]}}, {8{~be[1]}}, {8{~be[0]}}};
      if (wr)
        rsp_q.push_back({err_en && n > 0, 32'hFFFFFFFF, 32'h0});
      else
        rsp_q.push_back({err_en && n > 0, m,
          (big ? swap(mem_word) : mem_word) & m});
    end
  endtask

  // Offer one request, wait bounded for acceptance
  task send(input logic wr, input logic [3:0] be, input logic [31:0] wd);
    integer n;
    begin
      plan(wr, be, wd);
      req_write = wr;
      req_be_b = be;
      req_wdata = wd;
      req_valid = 1'b1;
      n = 0;
      while (req_ready !== 1'b1 && n < 200)
      begin
        @(negedge core_clk);
        n = n + 1;
      end
      if (n == 200)
      begin
        miscompares = miscompares + 1;
        stop_test;
      end
      @(negedge core_clk);
    end
  endtask

  // Release request and wait bounded for all results
  task drain;
    integer n;
    begin
      req_valid = 1'b0;
      n = 0;
      while ((lb_q.size() + rsp_q.size() != 0 || busy_r !== 1'b0) && n < 3000)
      begin
        @(negedge core_clk);
        n = n + 1;
      end
      if (n == 3000)
      begin
        miscompares = miscompares + 1;
        stop_test;
      end
    end
  endtask

  // Takes the oldest note whenever a result appears
  always @(posedge core_clk)
  begin : mon
    logic [64:0] e;
    logic [63:0] s, x;
    if (rst_b && lb_valid_r && lb_ack)
    begin
      e = (lb_q.size() != 0) ? {28'h0, lb_q.pop_front()} : {65{1'b1}};
      s = {27'h0, lb_write_r, transfer_size_code_r, lb_addr_r, lb_wdata_r};
      check(s, e[63:0]);
    end
    if (rst_b && rsp_valid_r)
    begin
      e = (rsp_q.size() != 0) ? rsp_q.pop_front() : {65{1'b1}};
      s = {31'h0, rsp_err_r, rsp_rdata_r & e[63:32]};
      x = {31'h0, e[64], e[31:0]};
      check(s, x);
    end
  end

  // Main sequence over every order, invert and width
  initial
  begin
    integer o, p, i;
    logic [3:0] bes [10];
    bes = '{4'h0, 4'h3, 4'hC, 4'h7, 4'hB, 4'hD, 4'hE, 4'h5, 4'h1, 4'hF};
    repeat (4) @(negedge core_clk);
    check({63'h0, order_big_r}, 64'h1);
    check({63'h0, req_ready}, 64'h0);
    rst_b = 1'b1;
    repeat (2) @(negedge core_clk);
    check({63'h0, order_big_r}, 64'h0);
    for (o = 0; o < 4; o = o + 1)
      for (p = 0; p < 3; p = p + 1)
      begin
        lbo = o[0];
        inv = o[1];
        pw = p[1:0];
        stall = 2'($random(seed));
        mem_word = $random(seed);
        for (i = 0; i < 20; i = i + 1)
          send(i[0], bes[i/2], $random(seed));
        drain;
        check({63'h0, order_big_r}, {63'h0, lbo});
        $display("Order %0d invert %0d width %0d done", lbo, inv, pw);
      end
    err_en = 1'b1;
    pw = `PTL_PORT_32;
    send(1'b1, 4'h0, $random(seed));
    send(1'b0, 4'h5, $random(seed));
    drain;
    $display("Error reporting done");
    stop_test;
  end
endmodule // pci_target_endian_lane_mapper_test
